// ===== idecad_top.v
// Instruction decode addressing and I/O request control
`timescale 1ns/1ps
`include "idecad_defines.vh"
// Behaviour
// - Map instruction to 9-bit store address
// - Two 16x16 arrays, fixed or writable
// - High array by bits 15-12, low by 11-8
// - Decode only when test/sequence 00, group X1XX
// - Enabled interrupt overrides decode with interrupt address
// - Mode 11X0 suppresses decode; field-selection otherwise
// - High array bits 8-0 always contribute
// - Low bits 8-4 when high twelve/fifteen zero
// - Low bits 3-0 with bit ten and twelve/fifteen
// - Instruction bits 7-4 per fourteen/fifteen/low thirteen
// - Instruction bits 3-0 per thirteen/fifteen/low thirteen
// - Address bit 2 takes bit 03 on swap
// - High array bits 15-9 and low array bits 15-1 exported as class signals
// - Sequence 00, mode 111X issues I/O request
// - Start address from top, second, middle, branch msb
// - Mode 0010 stalls until I/O done
// - Request held while I/O control busy
module idecad_top #(
   parameter [255:0] HIGH_INIT = 256'h0,
   parameter [255:0] LOW_INIT = 256'h0
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Instruction buffer and microinstruction fields
   input wire [15:0] instr_buf,
   input wire [1:0] test_select_field,
   input wire [1:0] sequence_field,
   input wire [3:0] group_field,
   input wire [3:0] io_mode_field,
   input wire start_addr_top_bit,
   input wire start_addr_second_bit,
   input wire [3:0] start_addr_middle_field,
   input wire branch_field_msb,
   // Alternate address sources from the sequencer
   input wire irq_pending,
   input wire [8:0] irq_addr,
   input wire [8:0] field_sel_addr,
   input wire [8:0] other_addr,
   // Writable array option
   input wire array_writable,
   input wire high_wr_en,
   input wire low_wr_en,
   input wire [3:0] array_wr_addr,
   input wire [15:0] array_wr_data,
   // I/O control handshake (from the independent I/O sequencer)
   input wire io_busy,
   input wire io_accept,
   input wire io_done_n,
   // Addressing results
   output reg [8:0] next_store_addr,
   output reg decode_active,
   output reg [6:0] high_class_bits,
   output reg [14:0] low_class_bits,
   // I/O request outputs
   output reg io_request,
   output reg [7:0] io_start_addr,
   output reg exec_stall
);
   // *****************************
   // Decode arrays
   // *****************************
   wire [3:0] high_index;
   wire [3:0] low_index;
   wire [3:0] instr_mid;
   wire [3:0] instr_low;
   wire [15:0] high_word;
   wire [15:0] low_word;

   // Arrays are read combinationally, so the address follows the buffer in one cycle
   assign high_index = instr_buf[`IDECAD_HI_NIB_LSB +: 4];
   assign low_index = instr_buf[`IDECAD_LO_NIB_LSB +: 4];
   assign instr_mid = instr_buf[`IDECAD_MID_NIB_LSB +: 4];
   assign instr_low = instr_buf[3:0];

   idecad_array #(.INIT(HIGH_INIT)) u_high (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .writable(array_writable),
      .wr_en(high_wr_en),
      .wr_addr(array_wr_addr),
      .wr_data(array_wr_data),
      .rd_addr(high_index),
      .rd_data(high_word)
   );

   idecad_array #(.INIT(LOW_INIT)) u_low (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .writable(array_writable),
      .wr_en(low_wr_en),
      .wr_addr(array_wr_addr),
      .wr_data(array_wr_data),
      .rd_addr(low_index),
      .rd_data(low_word)
   );

   // *****************************
   // Mode decoding
   // *****************************
   wire seq_zero;
   wire decode_selected;
   wire mode_inhibit;
   wire io_req_cmd;
   wire wait_done_cmd;
   wire decode_en;

   assign seq_zero = (sequence_field == `IDECAD_SEQ_NONE);
   assign decode_selected = (test_select_field == `IDECAD_TEST_NONE) && seq_zero && group_field[2];
   assign mode_inhibit = (io_mode_field[3:2] == 2'h3) && !io_mode_field[0];
   assign io_req_cmd = seq_zero && (io_mode_field[3:1] == 3'h7);
   assign wait_done_cmd = seq_zero && (io_mode_field == `IDECAD_MODE_WAIT_DONE);
   assign decode_en = decode_selected && !mode_inhibit && !irq_pending;

   // *****************************
   // Address components
   // *****************************
   wire hb10;
   wire hb12_or15_low;
   wire hb15_low_la13;
   wire en_low_high;
   wire en_low_low;
   wire en_instr_mid;
   wire en_instr_low;
   wire swap_bit_two;
   wire [8:0] comp_high;
   wire [8:0] comp_low_hi;
   wire [8:0] comp_low_lo;
   wire [3:0] mid_nib;
   wire [8:0] comp_mid;
   wire [8:0] comp_lo_nib;
   wire [8:0] decoded_addr;

   assign hb10 = high_word[`IDECAD_HB_TEN];
   assign hb12_or15_low = !high_word[`IDECAD_HB_TWELVE] || !high_word[`IDECAD_HB_FIFTEEN];
   assign hb15_low_la13 = !high_word[`IDECAD_HB_FIFTEEN] && low_word[`IDECAD_LB_THIRTEEN];

   // One enable per component except comp_high, each taken straight from the array words
   assign en_low_high = hb12_or15_low;
   assign en_low_low = hb12_or15_low && hb10;
   assign en_instr_mid = !high_word[`IDECAD_HB_FOURTEEN] || hb15_low_la13;
   assign en_instr_low = !high_word[`IDECAD_HB_THIRTEEN] || hb15_low_la13;
   assign swap_bit_two = high_word[`IDECAD_HB_SWAP] && low_word[`IDECAD_LB_NINE];

   assign comp_high = high_word[8:0];
   // Disabled components are zero so a plain OR gives the address
   assign comp_low_hi = en_low_high ? {low_word[8:4], 4'h0} : 9'h000;
   assign comp_low_lo = en_low_low ? {5'h00, low_word[3:0]} : 9'h000;
   // Swap bit 06 for bit 03 into address bit 2
   assign mid_nib = swap_bit_two ? {instr_mid[3], instr_low[3], instr_mid[1:0]} : instr_mid;
   assign comp_mid = en_instr_mid ? {5'h00, mid_nib} : 9'h000;
   assign comp_lo_nib = en_instr_low ? {5'h00, instr_low} : 9'h000;
   assign decoded_addr = comp_high | comp_low_hi | comp_low_lo | comp_mid | comp_lo_nib;

   // *****************************
   // Address select
   // *****************************
   localparam SRC_OTHER = 2'h0;
   localparam SRC_IRQ = 2'h1;
   localparam SRC_DECODE = 2'h2;
   localparam SRC_FIELD = 2'h3;

   reg [1:0] addr_source;
   reg [8:0] next_addr_sel;

   // Interrupts outrank the decoder, which outranks field selection
   always @* begin
      if (irq_pending) begin
         addr_source = SRC_IRQ;
      end else if (decode_selected && !mode_inhibit) begin
         addr_source = SRC_DECODE;
      end else if (decode_selected) begin
         addr_source = SRC_FIELD;
      end else begin
         addr_source = SRC_OTHER;
      end
   end

   always @* begin
      case (addr_source)
         SRC_IRQ: begin
            next_addr_sel = irq_addr;
         end
         SRC_DECODE: begin
            next_addr_sel = decoded_addr;
         end
         SRC_FIELD: begin
            next_addr_sel = field_sel_addr;
         end
         default: begin
            next_addr_sel = other_addr;
         end
      endcase
   end

   // *****************************
   // Two-stage input synchroniser for io_done_n of the I/O handshake
   // *****************************
   reg done_n_s1;
   reg done_n_s2;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_n_s1 <= 1'b1;
         done_n_s2 <= 1'b1;
      end else begin
         done_n_s1 <= io_done_n;
         done_n_s2 <= done_n_s1;
      end
   end

   // *****************************
   // I/O request and wait state machine
   // *****************************
   localparam ST_RUN = 2'h0;
   localparam ST_REQ_HOLD = 2'h1;
   localparam ST_WAIT_DONE = 2'h2;

   reg [1:0] state;
   reg [1:0] next_state;

   // Busy and accept come from logic on this clock, so they are read directly
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (io_req_cmd && !io_accept) begin
               next_state = ST_REQ_HOLD;
            end else if (wait_done_cmd && done_n_s2) begin
               next_state = ST_WAIT_DONE;
            end
         end
         ST_REQ_HOLD: begin
            if (io_accept && !io_busy) begin
               next_state = ST_RUN;
            end
         end
         ST_WAIT_DONE: begin
            if (!done_n_s2) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // *****************************
   // Address register
   // *****************************
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         next_store_addr <= `IDECAD_ADDR_RST;
         decode_active <= 1'b0;
      end else begin
         // The address is frozen while execution is stalled
         if (next_state == ST_RUN) begin
            next_store_addr <= next_addr_sel;
         end
         decode_active <= decode_en;
      end
   end

   // *****************************
   // Instruction class outputs
   // *****************************
   // Overlap with the address bits is harmless; option logic takes what it needs
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         high_class_bits <= 7'h00;
         low_class_bits <= 15'h0000;
      end else begin
         high_class_bits <= high_word[15:9];
         low_class_bits <= low_word[15:1];
      end
   end

   // *****************************
   // I/O request outputs
   // *****************************
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_request <= 1'b0;
         io_start_addr <= `IDECAD_IO_ADDR_RST;
         exec_stall <= 1'b0;
      end else begin
         io_request <= (next_state == ST_REQ_HOLD) || (io_req_cmd && state == ST_RUN && !io_accept);
         // Captured only on issue, so a held request keeps its start address
         if (io_req_cmd && state == ST_RUN) begin
            io_start_addr <= {start_addr_top_bit, start_addr_second_bit, start_addr_middle_field,
                              branch_field_msb, 1'b0};
         end
         exec_stall <= (next_state != ST_RUN);
      end
   end
endmodule // idecad_top

// ===== idecad_defines.vh
// Constants for the instruction decode and addressing block
`ifndef IDECAD_DEFINES_VH
`define IDECAD_DEFINES_VH
// Array geometry
`define IDECAD_ARRAY_DEPTH 16
`define IDECAD_WORD_W 16
`define IDECAD_ADDR_W 9
`define IDECAD_IO_ADDR_W 8
// Instruction buffer nibble positions
`define IDECAD_HI_NIB_LSB 12
`define IDECAD_LO_NIB_LSB 8
`define IDECAD_MID_NIB_LSB 4
// High array control bit positions
`define IDECAD_HB_SWAP 0
`define IDECAD_HB_TEN 10
`define IDECAD_HB_TWELVE 12
`define IDECAD_HB_THIRTEEN 13
`define IDECAD_HB_FOURTEEN 14
`define IDECAD_HB_FIFTEEN 15
// Low array control bit positions
`define IDECAD_LB_NINE 9
`define IDECAD_LB_THIRTEEN 13
// Field codes
`define IDECAD_TEST_NONE 2'h0
`define IDECAD_SEQ_NONE 2'h0
`define IDECAD_MODE_WAIT_DONE 4'h2
`define IDECAD_MODE_IO_NODEC 4'he
// Reset values
`define IDECAD_ADDR_RST 9'h000
`define IDECAD_IO_ADDR_RST 8'h00
`endif

// ===== idecad_array.v
// One 16 by 16 decode array, fixed contents or writable
`timescale 1ns/1ps
module idecad_array #(
   parameter [255:0] INIT = 256'h0
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Option select and write port
   input wire writable,
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [15:0] wr_data,
   // Read port
   input wire [3:0] rd_addr,
   output wire [15:0] rd_data
);
   reg [15:0] mem [0:15];
   integer i;
   wire [15:0] fixed_word;

   // The writable copy starts equal to the fixed contents after reset
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < 16; i = i + 1) begin
            mem[i] <= INIT[i*16 +: 16];
         end
      end else if (writable && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign fixed_word = INIT[rd_addr*16 +: 16];
   assign rd_data = writable ? mem[rd_addr] : fixed_word;
endmodule // idecad_array

// ===== idecad_checker.sv
// Port-level assertions for the decode addressing block
`timescale 1ns/1ps
module idecad_checker (
   // Clock, reset and fields
   input wire sys_clk,
   input wire reset_n,
   input wire [1:0] test_select_field,
   input wire [1:0] sequence_field,
   input wire [3:0] group_field,
   input wire [3:0] io_mode_field,
   input wire irq_pending,
   input wire [8:0] irq_addr,
   input wire [8:0] field_sel_addr,
   input wire [8:0] other_addr,
   input wire io_busy,
   input wire io_accept,
   input wire io_done_n,
   // Outputs
   input wire [8:0] next_store_addr,
   input wire decode_active,
   input wire io_request,
   input wire exec_stall
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire sel = test_select_field == 2'h0 && sequence_field == 2'h0 && group_field[2];
   wire inhib = io_mode_field[3:2] == 2'h3 && !io_mode_field[0];
   wire io_iss = sequence_field == 2'h0 && io_mode_field[3:1] == 3'h7;
   // A stalled cycle holds the address, so each source check skips it
   a_irq_first: assert property (irq_pending ##1 !exec_stall
      |-> next_store_addr == $past(irq_addr) && !decode_active) else $error("interrupt address not taken");
   a_decode_used: assert property (sel && !inhib && !irq_pending ##1 !exec_stall
      |-> decode_active) else $error("decode not used");
   a_field_select: assert property (sel && inhib && !irq_pending ##1 !exec_stall
      |-> next_store_addr == $past(field_sel_addr) && !decode_active) else $error("field select not taken");
   a_other_addr: assert property (!sel && !irq_pending ##1 !exec_stall
      |-> next_store_addr == $past(other_addr) && !decode_active) else $error("other address not taken");
   a_io_issue: assert property (io_iss && !io_request && !io_accept |=> io_request)
      else $error("request not issued");
   a_io_hold: assert property (io_request && !(io_accept && !io_busy) |=> io_request && exec_stall)
      else $error("request dropped early");
   a_io_drop: assert property (io_request && io_accept && !io_busy && !io_iss |=> !io_request)
      else $error("request kept after accept");
   a_done_release: assert property (!io_done_n && !io_request |-> ##[1:4] !exec_stall)
      else $error("stall not released");
endmodule // idecad_checker

bind idecad_top idecad_checker chk (.*);

// ===== idecad_io_model.sv
// Model of the I/O control sequencer facing the block
`timescale 1ns/1ps
module idecad_io_model (
   // Clock, reset and bench commands
   input wire sys_clk,
   input wire reset_n,
   input wire set_busy,
   input wire finish,
   // Handshake with the block
   input wire io_request,
   output reg io_busy,
   output reg io_accept,
   output reg io_done_n
);
   reg [15:0] ctrl_buf;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_busy <= 1'b0;
         io_accept <= 1'b0;
         io_done_n <= 1'b1;
         ctrl_buf <= 16'h0000;
      end else begin
         io_accept <= io_request && !io_busy && !io_accept;
         io_done_n <= !finish;
         // Busy rises only after the accept cycle, so the block sees accept with idle
         if (io_accept) begin
            io_busy <= 1'b1;
            ctrl_buf <= 16'h0088;
         end else if (set_busy) begin
            io_busy <= 1'b1;
         end else if (finish) begin
            io_busy <= 1'b0;
         end
      end
   end
endmodule // idecad_io_model

// ===== idecad_top_tb.sv
// Self-checking bench for the decode addressing block
`timescale 1ns/1ps
module idecad_top_tb;
   reg sys_clk = 1'b0, reset_n = 1'b0;
   reg [15:0] instr_buf = 16'h0000, array_wr_data = 16'h0000;
   reg [1:0] test_select_field = 2'h0, sequence_field = 2'h1;
   reg [3:0] group_field = 4'h0, io_mode_field = 4'h0, start_addr_middle_field = 4'h0, array_wr_addr = 4'h0;
   reg start_addr_top_bit = 1'b0, start_addr_second_bit = 1'b0, branch_field_msb = 1'b0;
   reg irq_pending = 1'b0, array_writable = 1'b1, high_wr_en = 1'b0, low_wr_en = 1'b0;
   reg [8:0] irq_addr = 9'h1a3, field_sel_addr = 9'h0c5, other_addr = 9'h15a;
   reg set_busy = 1'b0, finish = 1'b0;
   wire io_busy, io_accept, io_done_n, decode_active, io_request, exec_stall;
   wire [8:0] next_store_addr;
   wire [6:0] high_class_bits;
   wire [14:0] low_class_bits;
   wire [7:0] io_start_addr;
   integer fail_count = 0, check_count = 0, i;
   reg [15:0] hw_tab [0:4], lw_tab [0:4], in_tab [0:4];
   idecad_top uut (.*);
   idecad_io_model io_model (.*);
   initial forever #2.5 sys_clk = !sys_clk;
   task check(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("Checks %0d, mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task wr(input hi, input [3:0] a, input [15:0] d);
      begin
         @(negedge sys_clk);
         high_wr_en = hi;
         low_wr_en = !hi;
         array_wr_addr = a;
         array_wr_data = d;
         @(negedge sys_clk);
         high_wr_en = 1'b0;
         low_wr_en = 1'b0;
      end
   endtask
   task pulse_finish;
      begin
         finish = 1'b1;
         @(negedge sys_clk);
         finish = 1'b0;
      end
   endtask
   function [8:0] dec_exp(input [15:0] h, input [15:0] l, input [15:0] n);
      reg [3:0] mid;
      reg f;
      begin
         f = !h[15] && l[13];
         mid = n[7:4];
         if (h[0] && l[9]) mid[2] = n[3];
         dec_exp = h[8:0];
         if (!h[12] || !h[15]) dec_exp = dec_exp | {l[8:4], 4'h0};
         if (h[10] && (!h[12] || !h[15])) dec_exp = dec_exp | l[3:0];
         if (!h[14] || f) dec_exp = dec_exp | mid;
         if (!h[13] || f) dec_exp = dec_exp | n[3:0];
      end
   endfunction
   initial begin
      #20000;
      fail_count = fail_count + 1;
      final_report;
   end
   initial begin
      hw_tab[0] = 16'hf0a5; lw_tab[0] = 16'hffff; in_tab[0] = 16'hf1c3;
      hw_tab[1] = 16'h7400; lw_tab[1] = 16'h0123; in_tab[1] = 16'h7277;
      hw_tab[2] = 16'h6001; lw_tab[2] = 16'h2200; in_tab[2] = 16'h6340;
      hw_tab[3] = 16'hb000; lw_tab[3] = 16'h0000; in_tab[3] = 16'hb45a;
      hw_tab[4] = 16'hd000; lw_tab[4] = 16'h0000; in_tab[4] = 16'hd55a;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'b1;
      sequence_field = 2'h0;
      group_field = 4'h4;
      for (i = 0; i < 5; i = i + 1) begin
         wr(1'b1, in_tab[i][15:12], hw_tab[i]);
         wr(1'b0, in_tab[i][11:8], lw_tab[i]);
         instr_buf = in_tab[i];
         @(negedge sys_clk);
         check(next_store_addr, dec_exp(hw_tab[i], lw_tab[i], in_tab[i]));
         check(decode_active, 1);
         check({high_class_bits, low_class_bits}, {hw_tab[i][15:9], lw_tab[i][15:1]});
      end
      // Strobe with the option off must leave the writable word alone
      array_writable = 1'b0;
      wr(1'b1, 4'hd, 16'h0000);
      // With the option off the fixed contents, all zero here, do the decoding
      check(next_store_addr, dec_exp(16'h0000, 16'h0000, in_tab[4]));
      array_writable = 1'b1;
      @(negedge sys_clk);
      check(next_store_addr, dec_exp(hw_tab[4], lw_tab[4], in_tab[4]));
      irq_pending = 1'b1;
      @(negedge sys_clk);
      check(next_store_addr, irq_addr);
      irq_pending = 1'b0;
      io_mode_field = 4'hc;
      @(negedge sys_clk);
      check(next_store_addr, field_sel_addr);
      group_field = 4'hb;
      @(negedge sys_clk);
      check(next_store_addr, other_addr);
      set_busy = 1'b1;
      @(negedge sys_clk);
      set_busy = 1'b0;
      // Request code that also inhibits decoding, with decoding selected
      io_mode_field = 4'he;
      group_field = 4'h4;
      start_addr_top_bit = 1'b1;
      start_addr_middle_field = 4'h9;
      branch_field_msb = 1'b1;
      @(negedge sys_clk);
      check(decode_active, 0);
      io_mode_field = 4'h0;
      repeat (3) @(negedge sys_clk);
      check({io_request, exec_stall}, 2'h3);
      check(io_start_addr, 8'ha6);
      pulse_finish;
      for (i = 0; i < 10 && io_request; i = i + 1) @(negedge sys_clk);
      check(io_request, 0);
      repeat (4) @(negedge sys_clk);
      io_mode_field = 4'h2;
      @(negedge sys_clk);
      io_mode_field = 4'h0;
      @(negedge sys_clk);
      check(exec_stall, 1);
      pulse_finish;
      for (i = 0; i < 6 && exec_stall; i = i + 1) @(negedge sys_clk);
      check(exec_stall, 0);
      final_report;
   end
endmodule // idecad_top_tb
